// ===== include/arsr_map.vh
/*
 Register map, field positions and reset values for the converter result
 and offset coefficient register block. Definitions only.
*/
`ifndef ARSR_MAP_VH
`define ARSR_MAP_VH

`define ARSR_ADDR_W 32
`define ARSR_CUR_RESULT_ADDR 32'h40030020
`define ARSR_VOLT_RESULT_ADDR 32'h40030024
`define ARSR_CUR_OFS_ADDR 32'h40030030
`define ARSR_VOLT_OFS_ADDR 32'h40030034
`define ARSR_CTRL_ADDR 32'h40030050
`define ARSR_STAT_ADDR 32'h40030054
`define ARSR_CUR_GAIN_ADDR 32'h40030058

`define ARSR_RESULT_RST 32'h00000000
`define ARSR_OFS_W 24
`define ARSR_OFS_SIGN 23
`define ARSR_OFS_CAL_DEFAULT 24'h000000
`define ARSR_VALID_BIT 0

`define ARSR_CTRL_CUR_CODE 0
`define ARSR_CTRL_VOLT_CODE 1
`define ARSR_CTRL_CNT_EN 2
`define ARSR_CTRL_CUR_CAL 3
`define ARSR_CTRL_VOLT_CAL 4
`define ARSR_CTRL_W 5

`define ARSR_STAT_CUR_RDY 0
`define ARSR_STAT_VOLT_RDY 1

`define ARSR_GAIN_SEL_W 4
`define ARSR_GAIN_MAX 4'h9
`define ARSR_CNT_W 16
`define ARSR_CNT_LIMIT_RST 16'h0001
`define ARSR_CONV_W 24
`define ARSR_SETTLE_CONV 2

`endif

// ===== hw/arsr_cur_format.v
/*
 Formats a raw current conversion word into the result layout for the
 selected gain. Assumes a 24-bit raw word, signed unless unipolar, gain code 0..9 meaning
 gain 1 to 512 in powers of two.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"

module arsr_cur_format #(
  parameter RAW_W = 24
) (
  input wire [RAW_W-1:0] raw,
  input wire [3:0] gain_sel,
  input wire unipolar,
  input wire cal_mode,
  output reg [31:0] word
);
  reg [31:0] ext;
  reg [31:0] sh;
  reg [3:0] g;
  always @* begin
    g = (gain_sel > `ARSR_GAIN_MAX) ? `ARSR_GAIN_MAX : gain_sel;
    if (unipolar) begin
      ext = {8'h00, raw};
    end else begin
      ext = {{8{raw[RAW_W-1]}}, raw};
    end
    // Data shifted left by 9 bits at gain 1, moving down one per gain step
    sh = ext << (4'd9 - g);
    // Gain 512 keeps bits 23..0 and clears none; at lower gains the bits below the data field clear
    sh = sh & ~((32'h00000001 << (4'd9 - g)) - 32'h00000001);
    if (cal_mode) begin
      word = {8'h00, raw};
    end else begin
      word = sh;
    end
  end
endmodule // arsr_cur_format

`default_nettype wire

// ===== hw/arsr_volt_format.v
/*
 Fixed layout for the voltage converter result word: 24-bit data in
 bits 24..1 (bits 23..0 in cal mode), no gain dependence. Assumes a 24-bit raw word.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"

module arsr_volt_format #(
  parameter RAW_W = 24
) (
  input wire [RAW_W-1:0] raw,
  input wire unipolar,
  input wire cal_mode,
  output reg [31:0] word
);
  always @* begin
    if (cal_mode) begin
      word = {8'h00, raw};
    end else if (unipolar) begin
      word = {7'h00, raw, 1'b0};
    end else begin
      word = {{7{raw[RAW_W-1]}}, raw, 1'b0};
    end
  end
endmodule // arsr_volt_format

`default_nettype wire

// ===== hw/arsr_regs.v
/*
 Result holding and offset coefficient registers for the current and
 voltage converters, with ready flags, result counter gating and
 reconfiguration settling. Assumes converter front-ends deliver one-cycle
 done pulses with raw words on ref_clk and a plain register port.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"

module arsr_regs #(
  parameter RAW_W = `ARSR_CONV_W,
  parameter CNT_W = `ARSR_CNT_W,
  parameter SETTLE = `ARSR_SETTLE_CONV,
  parameter [`ARSR_OFS_W-1:0] CUR_OFS_CAL = `ARSR_OFS_CAL_DEFAULT,
  parameter [`ARSR_OFS_W-1:0] VOLT_OFS_CAL = `ARSR_OFS_CAL_DEFAULT
) (
  input wire ref_clk,
  input wire rst,
  input wire [`ARSR_ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire core_off,
  input wire cur_done,
  input wire [RAW_W-1:0] cur_raw,
  input wire cur_raw_bad,
  input wire volt_done,
  input wire [RAW_W-1:0] volt_raw,
  input wire volt_raw_bad,
  input wire volt_reconfig,
  input wire [CNT_W-1:0] result_count_limit,
  output wire result_counter_enable,
  output wire [CNT_W-1:0] result_count_value,
  output wire [`ARSR_OFS_W-1:0] current_offset_coef,
  output wire [`ARSR_OFS_W-1:0] voltage_offset_coef,
  output wire current_ready_flag,
  output wire voltage_ready_flag,
  output reg conv_event
);
  reg [31:0] cur_result_r;
  reg [31:0] volt_result_r;
  reg [`ARSR_OFS_W-1:0] cur_ofs_r;
  reg [`ARSR_OFS_W-1:0] volt_ofs_r;
  reg [`ARSR_CTRL_W-1:0] ctrl_r;
  reg [`ARSR_GAIN_SEL_W-1:0] gain_r;
  reg cur_rdy_r;
  reg volt_rdy_r;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg [3:0] settle_r;
  reg ofs_loaded_r;
  wire [31:0] cur_word;
  wire [31:0] volt_word;
  wire cnt_en;
  wire cur_hit;
  wire cur_take;
  wire volt_take;
  wire rd_cur;
  wire rd_volt;

  assign cnt_en = ctrl_r[`ARSR_CTRL_CNT_EN];
  assign result_counter_enable = cnt_en;
  assign result_count_value = cnt_r;
  assign current_offset_coef = cur_ofs_r;
  assign voltage_offset_coef = volt_ofs_r;
  assign current_ready_flag = cur_rdy_r;
  assign voltage_ready_flag = volt_rdy_r;

  arsr_cur_format #(
    .RAW_W(RAW_W)
  ) u_cur_fmt (
    .raw(cur_raw),
    .gain_sel(gain_r),
    .unipolar(ctrl_r[`ARSR_CTRL_CUR_CODE]),
    .cal_mode(ctrl_r[`ARSR_CTRL_CUR_CAL]),
    .word(cur_word)
  );

  arsr_volt_format #(
    .RAW_W(RAW_W)
  ) u_volt_fmt (
    .raw(volt_raw),
    .unipolar(ctrl_r[`ARSR_CTRL_VOLT_CODE]),
    .cal_mode(ctrl_r[`ARSR_CTRL_VOLT_CAL]),
    .word(volt_word)
  );

  assign cur_hit = !cnt_en || (cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}
    >= result_count_limit);

  // ready blocks writes unless core off
  assign cur_take = cur_done && cur_hit && (!cur_rdy_r || core_off);

  // ready blocks writes unless core off
  assign volt_take = volt_done && !volt_reconfig && settle_r == 4'h0 &&
    (!volt_rdy_r || core_off);

  assign rd_cur = rd_stb && addr == `ARSR_CUR_RESULT_ADDR;
  assign rd_volt = rd_stb && addr == `ARSR_VOLT_RESULT_ADDR;

  // counter held in reset when disabled
  always @* begin
    cnt_nxt = cnt_r;
    if (!cnt_en) begin
      cnt_nxt = {CNT_W{1'b0}};
    end else if (cur_done) begin
      if (cur_hit) begin
        cnt_nxt = {CNT_W{1'b0}};
      end else begin
        cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {CNT_W{1'b0}};
      conv_event <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      // event per conversion or at limit
      conv_event <= cur_done && cur_hit;
    end
  end

  // Current result and ready flag
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_result_r <= `ARSR_RESULT_RST;
      cur_rdy_r <= 1'b0;
    end else begin
      if (cur_take) begin
        cur_result_r <= {cur_word[31:1], cur_raw_bad};
        cur_rdy_r <= 1'b1;
      end else if (rd_cur) begin
        cur_rdy_r <= 1'b0;
      end
    end
  end

  // Voltage result, ready flag and settle count
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      volt_result_r <= `ARSR_RESULT_RST;
      volt_rdy_r <= 1'b0;
      settle_r <= 4'h0;
    end else begin
      // reconfig touches only the voltage path
      if (volt_reconfig) begin
        settle_r <= SETTLE[3:0];
        volt_rdy_r <= 1'b0;
      end else begin
        if (volt_done && settle_r != 4'h0) begin
          settle_r <= settle_r - 4'h1;
        end
        if (volt_take) begin
          volt_result_r <= {volt_word[31:1], volt_raw_bad};
          volt_rdy_r <= 1'b1;
        end else if (rd_volt) begin
          volt_rdy_r <= 1'b0;
        end
      end
    end
  end

  // Software-writable registers; result registers are read-only
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ofs_r <= `ARSR_OFS_CAL_DEFAULT;
      volt_ofs_r <= `ARSR_OFS_CAL_DEFAULT;
      ctrl_r <= {`ARSR_CTRL_W{1'b0}};
      gain_r <= {`ARSR_GAIN_SEL_W{1'b0}};
      ofs_loaded_r <= 1'b0;
    end else if (!ofs_loaded_r) begin
      // Factory calibration values loaded at release of reset
      cur_ofs_r <= CUR_OFS_CAL;
      volt_ofs_r <= VOLT_OFS_CAL;
      ofs_loaded_r <= 1'b1;
    end else if (wr_stb) begin
      case (addr)
        `ARSR_CUR_OFS_ADDR: begin
          cur_ofs_r <= wdata[`ARSR_OFS_W-1:0];
        end
        `ARSR_VOLT_OFS_ADDR: begin
          volt_ofs_r <= wdata[`ARSR_OFS_W-1:0];
        end
        `ARSR_CTRL_ADDR: begin
          ctrl_r <= wdata[`ARSR_CTRL_W-1:0];
        end
        `ARSR_CUR_GAIN_ADDR: begin
          gain_r <= wdata[`ARSR_GAIN_SEL_W-1:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `ARSR_CUR_RESULT_ADDR: rdata <= cur_result_r;
        `ARSR_VOLT_RESULT_ADDR: rdata <= volt_result_r;
        `ARSR_CUR_OFS_ADDR: rdata <= {8'h00, cur_ofs_r};
        `ARSR_VOLT_OFS_ADDR: rdata <= {8'h00, volt_ofs_r};
        `ARSR_CTRL_ADDR: rdata <= {27'h0000000, ctrl_r};
        `ARSR_STAT_ADDR: rdata <= {30'h00000000, volt_rdy_r, cur_rdy_r};
        `ARSR_CUR_GAIN_ADDR: rdata <= {28'h0000000, gain_r};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // arsr_regs

`default_nettype wire

// ===== tb/arsr_regs_sva.sv
/* Port checker for arsr_regs.
 Bound from tb; sees only the design's ports. */
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"
module arsr_regs_sva #(
  parameter CNT_W = `ARSR_CNT_W
) (
  input wire ref_clk,
  input wire rst,
  input wire [`ARSR_ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire cur_done,
  input wire volt_reconfig,
  input wire [CNT_W-1:0] result_count_limit,
  input wire result_counter_enable,
  input wire [CNT_W-1:0] result_count_value,
  input wire [`ARSR_OFS_W-1:0] current_offset_coef,
  input wire current_ready_flag,
  input wire voltage_ready_flag,
  input wire conv_event
);
  wire [`ARSR_OFS_W-1:0] wlo = wdata[`ARSR_OFS_W-1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cur_rd;
    rd_stb && addr == `ARSR_CUR_RESULT_ADDR && !cur_done;
  endsequence
  sequence s_cnt_step;
    result_counter_enable && cur_done && !wr_stb &&
      result_count_value + 1'b1 < result_count_limit;
  endsequence
  property p_cur_set;
    cur_done && !current_ready_flag && !result_counter_enable
      |=> current_ready_flag;
  endproperty
  a_cur_set: assert property (p_cur_set)
    else $error("ready not set");
  property p_cur_hold;
    current_ready_flag && !rd_stb |=> current_ready_flag;
  endproperty
  a_cur_hold: assert property (p_cur_hold)
    else $error("ready lost");
  property p_cur_clr;
    s_cur_rd |=> !current_ready_flag;
  endproperty
  a_cur_clr: assert property (p_cur_clr)
    else $error("ready kept");
  property p_volt_hold;
    voltage_ready_flag && !rd_stb && !volt_reconfig |=> voltage_ready_flag;
  endproperty
  a_volt_hold: assert property (p_volt_hold)
    else $error("volt ready lost");
  property p_ev_every;
    cur_done && !result_counter_enable |=> conv_event;
  endproperty
  a_ev_every: assert property (p_ev_every)
    else $error("event missing");
  property p_ev_cause;
    !cur_done |=> !conv_event;
  endproperty
  a_ev_cause: assert property (p_ev_cause)
    else $error("stray event");
  property p_cnt_inc;
    s_cnt_step |=> result_count_value == $past(result_count_value) + 1'b1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("count step");
  property p_ofs;
    wr_stb && addr == `ARSR_CUR_OFS_ADDR |=> current_offset_coef == $past(wlo);
  endproperty
  a_ofs: assert property (p_ofs)
    else $error("offset write");
endmodule // arsr_regs_sva
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for arsr_regs.
 Owns clock and reset; drives register port and converter pulses. */
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"
module tb;
  localparam [31:0] CR = `ARSR_CUR_RESULT_ADDR;
  localparam [31:0] VR = `ARSR_VOLT_RESULT_ADDR;
  localparam [31:0] CT = `ARSR_CTRL_ADDR;
  logic ref_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, core_off = 0;
  logic cur_done = 0, volt_done = 0, cur_raw_bad = 0, volt_raw_bad = 0;
  logic volt_reconfig = 0, cen, crdy, vrdy, cev, rdc = 0, rdv = 0, hit;
  logic [31:0] addr = 0, wdata = 0, rdata, t, ec = 0, ev = 0;
  logic [23:0] cur_raw = 0, volt_raw = 0, cof, vof;
  logic [15:0] lim = 0, cval, lf = 16'h0010;
  logic [4:0] ctl = 0;
  logic [3:0] gn = 0;
  int fails = 0, compares = 0, cnt = 0, skip = 0, i;
  arsr_regs i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .core_off(core_off), .cur_done(cur_done), .cur_raw(cur_raw),
    .cur_raw_bad(cur_raw_bad), .volt_done(volt_done), .volt_raw(volt_raw),
    .volt_raw_bad(volt_raw_bad), .volt_reconfig(volt_reconfig),
    .result_count_limit(lim), .result_counter_enable(cen),
    .result_count_value(cval), .current_offset_coef(cof),
    .voltage_offset_coef(vof), .current_ready_flag(crdy),
    .voltage_ready_flag(vrdy), .conv_event(cev));
  initial forever #50 ref_clk = ~ref_clk;
  function automatic [31:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    rnd = {lf, lf ^ 16'h5a3c};
  endfunction
  function automatic [31:0] fc(input logic [23:0] r, input logic b);
    fc = (ctl[0] ? {8'h00, r} : {{8{r[23]}}, r}) << (9 - gn);
    fc[0] = b;
  endfunction
  function automatic [31:0] fv(input logic [23:0] r, input logic b);
    fv = {ctl[1] ? 7'h00 : {7{r[23]}}, r, b};
  endfunction
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [31:0] a, d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    if (a == CT) ctl = d[4:0];
    if (a == `ARSR_CUR_GAIN_ADDR) gn = d[3:0];
  endtask
  task rc(input logic [31:0] a, e);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
    if (a == CR) rdc = 0;
    if (a == VR) rdv = 0;
  endtask
  task cv(input logic c, v, input logic [31:0] r);
    @(posedge ref_clk);
    cur_done <= c;
    volt_done <= v;
    cur_raw <= r[23:0];
    cur_raw_bad <= r[31];
    volt_raw <= r[27:4];
    volt_raw_bad <= r[30];
    @(posedge ref_clk);
    cur_done <= 1'b0;
    volt_done <= 1'b0;
    hit = !ctl[2] || cnt + 1 >= lim;
    if (c) cnt = (ctl[2] && !hit) ? cnt + 1 : 0;
    if (c && hit && (!rdc || core_off)) begin
      ec = ctl[3] ? {8'h00, r[23:1], r[31]} : fc(r[23:0], r[31]);
      rdc = 1;
    end
    if (v && skip > 0) skip--;
    else if (v && (!rdv || core_off)) begin
      ev = ctl[4] ? {8'h00, r[27:5], r[30]} : fv(r[27:4], r[30]);
      rdv = 1;
    end
    #1;
    chk(32'(crdy), 32'(rdc));
    chk(32'(vrdy), 32'(rdv));
    chk(32'(cev), 32'(c && hit));
    chk(32'(cval), cnt);
  endtask
  task stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rc(CR, 0);
    rc(VR, 0);
    t = rnd();
    wr(`ARSR_CUR_OFS_ADDR, t);
    rc(`ARSR_CUR_OFS_ADDR, {8'h00, t[23:0]});
    chk({8'h00, cof}, {8'h00, t[23:0]});
    wr(`ARSR_VOLT_OFS_ADDR, ~t);
    rc(`ARSR_VOLT_OFS_ADDR, {8'h00, ~t[23:0]});
    chk({8'h00, vof}, {8'h00, ~t[23:0]});
    wr(CR, 32'hffffffff);
    wr(VR, 32'hffffffff);
    rc(CR, 0);
    rc(VR, 0);
    rc(32'h40030060, 0);
    $display("test 1 done");
    for (i = 0; i < 20; i++) begin
      wr(CT, {30'h0, i[1], i[1]});
      wr(`ARSR_CUR_GAIN_ADDR, i % 10);
      cv(1'b1, 1'b1, rnd());
      rc(`ARSR_STAT_ADDR, {30'h0, rdv, rdc});
      // results read only while ready is set
      rc(CR, ec);
      rc(VR, ev);
    end
    $display("test 2 done");
    repeat (2) cv(1'b1, 1'b1, rnd());
    rc(CR, ec);
    rc(VR, ev);
    @(posedge ref_clk);
    core_off <= 1'b1;
    repeat (2) cv(1'b1, 1'b1, rnd());
    rc(CR, ec);
    rc(VR, ev);
    @(posedge ref_clk);
    core_off <= 1'b0;
    $display("test 3 done");
    @(posedge ref_clk);
    volt_reconfig <= 1'b1;
    @(posedge ref_clk);
    volt_reconfig <= 1'b0;
    skip = `ARSR_SETTLE_CONV;
    repeat (3) cv(1'b1, 1'b1, rnd());
    rc(CR, ec);
    rc(VR, ev);
    $display("test 4 done");
    @(posedge ref_clk);
    lim <= 16'h0003;
    wr(CT, 32'h4);
    repeat (3) cv(1'b1, 1'b0, rnd());
    rc(CR, ec);
    wr(CT, 32'h18);
    cv(1'b1, 1'b1, rnd());
    rc(CR, ec);
    rc(VR, ev);
    wr(`ARSR_CUR_OFS_ADDR, ec >> 5);
    rc(`ARSR_CUR_OFS_ADDR, {8'h00, ec[28:5]});
    wr(`ARSR_VOLT_OFS_ADDR, ev >> 5);
    rc(`ARSR_VOLT_OFS_ADDR, {8'h00, ev[28:5]});
    wr(`ARSR_CUR_OFS_ADDR, 32'h00000000);
    rc(`ARSR_CUR_OFS_ADDR, 32'h00000000);
    $display("test 5 done");
    stop_test;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    fails++;
    stop_test;
  end
endmodule // tb
bind arsr_regs arsr_regs_sva #(.CNT_W(CNT_W)) i_chk (.ref_clk(ref_clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .cur_done(cur_done), .volt_reconfig(volt_reconfig),
  .result_count_limit(result_count_limit),
  .result_counter_enable(result_counter_enable),
  .result_count_value(result_count_value),
  .current_offset_coef(current_offset_coef),
  .current_ready_flag(current_ready_flag),
  .voltage_ready_flag(voltage_ready_flag), .conv_event(conv_event));
`default_nettype wire
